// ==== hw/angle_wave_unit.sv ====
// Electrical angle timer with sine waveform arithmetic unit.
// Assumes an Avalon-MM master, a pulse on position_detect from the
// position detector, and the PWM period from the PWM circuit.
//
// Operation
// R1: Trigger write restarts calculation, aborting current
// R2: Busy flag reads one while calculating
// R3: Sync enable: timer done or angle write starts
// R4: Irq select: timer done or calculation end
// R5: Direction bit: zero counts up, one down
// R6: Phase order: V,W at +-120, +-240 degrees
// R7: Clock select picks prescaler, live while running
// R8: Two-phase result is sine entry times scale
// R9: Three-phase: period plus/minus half term by angle
// R10: Calc and transfer enabled load compare registers
// R11: Calculate only when enabled; reads show results
// R12: Timer enable counts; clearing stops, zeroes angle
// R13: Correction n uses m+1 on n of 16
// R14: Period value sets clocks per angle step
// R15: Angle readable, writable; values above 17FH refused
// R16: Scale times sine, limited by PWM period
// R17: Capture latches angle on position detect
// R18: Software fills sine table via angle and port
// R19: Angle spans 0 to 383 and wraps
// R20: Calculation takes 35 machine cycles; the sequencer here stays busy for 140 clock cycles
// R21: Period below 010H treated as 010H
// R22: Compare writes ignored while autotransfer enabled
// R23: Prescaled tick counter reaching period advances angle
`timescale 1ns/1ns
`default_nettype none
module angle_wave_unit
   import angle_wave_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        position_detect,
   input  wire logic [15:0] pwm_period_setting,
   output logic [15:0]      u_phase_compare,
   output logic [15:0]      v_phase_compare,
   output logic [15:0]      w_phase_compare,
   output logic             angle_irq
);
   import angle_wave_pkg::*;

   timer_ctrl_t ctrl_a_ff;
   logic        sync_en_ff;
   logic        irq_sel_ff;
   period_t     period_ff;
   logic [15:0] scale_ff;
   logic [8:0]  angle_ff;
   logic [8:0]  capture_ff;
   logic [15:0] sine_ram [SINE_DEPTH];
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic        irq_ff;
   logic [5:0]  presc_ff;
   logic [12:0] step_ff;
   logic [3:0]  corr_acc_ff;
   calc_state_t state_ff;
   logic [7:0]  calc_cnt_ff;
   logic [8:0]  base_ff;
   logic [8:0]  ph_angle_ff;
   logic [15:0] ram_q_ff;
   logic [15:0] res_ff [3];
   logic [15:0] cmp_ff [3];

   logic        wr_en;
   logic [31:0] rd_val;
   logic        tick;
   logic [11:0] per_eff;
   logic [4:0]  corr_sum;
   logic [12:0] step_limit;
   logic [12:0] step_nxt;
   logic        timer_done;
   logic        angle_wr;
   logic        sw_trig;
   logic        calc_start;
   logic        calc_done;
   logic [1:0]  rd_phase;
   logic [8:0]  rd_addr;
   logic [15:0] calc_value;

   // Bus merge of byte lanes into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      merge16 = {be[1] ? wd[15:8] : old[15:8],
                 be[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   // Angle of a phase relative to the U angle
   function automatic logic [8:0] phase_angle(input logic [8:0] base,
                                              input logic [1:0] ph,
                                              input logic       rev);
      logic [9:0] ofs;
      logic [9:0] sum;
      ofs = 10'h000;
      if (ph == 2'd1) begin
         ofs = rev ? ANGLE_TWO_THIRD : ANGLE_THIRD;             // [R6]
      end else if (ph == 2'd2) begin
         ofs = rev ? ANGLE_THIRD : ANGLE_TWO_THIRD;             // [R6]
      end
      sum = {1'b0, base} + ofs;
      if (sum >= ANGLE_SPAN) begin
         sum = sum - ANGLE_SPAN;
      end
      phase_angle = sum[8:0];
   endfunction : phase_angle

   // Bus slave: one wait cycle, then a single cycle with waitrequest low
   assign wr_en = avs_write & ~wait_ff;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wait_ff <= 1'b1;
      end else if ((avs_read | avs_write) & wait_ff) begin
         wait_ff <= 1'b0;
      end else begin
         wait_ff <= 1'b1;
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      case (avs_address)
         OFS_CALC_CTRL_B: begin
            rd_val[BIT_BUSY]    = (state_ff == CALC_RUN);  // [R2]
            rd_val[BIT_SYNC_EN] = sync_en_ff;
            rd_val[BIT_IRQ_SEL] = irq_sel_ff;
         end
         OFS_TIMER_CTRL_A: rd_val[7:0] = ctrl_a_ff;
         OFS_PERIOD:       rd_val[15:0] = period_ff;
         OFS_ANGLE:        rd_val[8:0] = angle_ff;          // [R15]
         OFS_SCALE:        rd_val[15:0] = scale_ff;
         OFS_CAPTURE:      rd_val[8:0] = capture_ff;
         OFS_CMP_U: begin
            rd_val[15:0] = ctrl_a_ff.waveform_calc_enable ?
                           res_ff[0] : cmp_ff[0];           // [R11]
         end
         OFS_CMP_V: begin
            rd_val[15:0] = ctrl_a_ff.waveform_calc_enable ?
                           res_ff[1] : cmp_ff[1];           // [R11]
         end
         OFS_CMP_W: begin
            rd_val[15:0] = ctrl_a_ff.waveform_calc_enable ?
                           res_ff[2] : cmp_ff[2];           // [R11]
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read & wait_ff) begin
         rdata_ff <= rd_val;
      end
   end

   // Control registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_a_ff  <= timer_ctrl_t'(RST_CTRL_A);
         sync_en_ff <= RST_CTRL_B[1];
         irq_sel_ff <= RST_CTRL_B[0];
         period_ff  <= period_t'(RST_PERIOD);
         scale_ff   <= RST_SCALE;
      end else if (wr_en) begin
         if (avs_address == OFS_TIMER_CTRL_A && avs_byteenable[0]) begin
            ctrl_a_ff <= timer_ctrl_t'(avs_writedata[7:0]);
         end
         if (avs_address == OFS_CALC_CTRL_B && avs_byteenable[0]) begin
            sync_en_ff <= avs_writedata[BIT_SYNC_EN];
            irq_sel_ff <= avs_writedata[BIT_IRQ_SEL];
         end
         if (avs_address == OFS_PERIOD) begin
            period_ff <= period_t'(merge16(period_ff, avs_writedata,
                                           avs_byteenable));
         end
         if (avs_address == OFS_SCALE) begin
            scale_ff <= merge16(scale_ff, avs_writedata, avs_byteenable);
         end
      end
   end

   assign sw_trig = wr_en & (avs_address == OFS_CALC_CTRL_B) &
                    avs_byteenable[0] & avs_writedata[BIT_SW_TRIG];
   assign angle_wr = wr_en & (avs_address == OFS_ANGLE) &
                     (avs_byteenable[1:0] == 2'b11) &
                     (avs_writedata[15:0] <= {7'h00, ANGLE_MAX}); // [R15]

   // Sine table, written at the current angle
   always_ff @(posedge mclk) begin
      if (wr_en && avs_address == OFS_SINE_PORT &&
          avs_byteenable[1:0] == 2'b11) begin
         sine_ram[angle_ff] <= avs_writedata[15:0];             // [R18]
      end
   end

   // Prescaler and step timing
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         presc_ff <= 6'h00;
      end else begin
         presc_ff <= presc_ff + 6'h01;
      end
   end

   always_comb begin
      case (ctrl_a_ff.timer_clock_select)                       // [R7]
         2'd0:    tick = &presc_ff[2:0];
         2'd1:    tick = &presc_ff[3:0];
         2'd2:    tick = &presc_ff[4:0];
         2'd3:    tick = &presc_ff[5:0];
         default: tick = 1'b0;
      endcase
   end

   assign per_eff = (period_ff.period_value < PERIOD_MIN) ?
                    PERIOD_MIN : period_ff.period_value;        // [R21]
   assign corr_sum = {1'b0, corr_acc_ff} +
                     {1'b0, period_ff.period_correction_count};
   assign step_limit = {1'b0, per_eff} + {12'h000, corr_sum[4]}; // [R13]
   assign step_nxt = step_ff + 13'h0001;
   assign timer_done = ctrl_a_ff.angle_timer_enable & tick &
                       (step_nxt >= step_limit);                // [R14]

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         step_ff     <= 13'h0000;
         corr_acc_ff <= 4'h0;
      end else if (!ctrl_a_ff.angle_timer_enable) begin
         step_ff     <= 13'h0000;
         corr_acc_ff <= 4'h0;
      end else if (timer_done) begin
         step_ff     <= 13'h0000;                               // [R23]
         corr_acc_ff <= corr_sum[3:0];                          // [R13]
      end else if (tick) begin
         step_ff <= step_nxt;                                   // [R23]
      end
   end

   // Electrical angle counter
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         angle_ff <= 9'h000;
      end else if (angle_wr) begin
         angle_ff <= avs_writedata[8:0];                        // [R15]
      end else if (wr_en && avs_address == OFS_TIMER_CTRL_A &&
                   avs_byteenable[0] && !avs_writedata[0]) begin
         angle_ff <= 9'h000;                                    // [R12]
      end else if (timer_done) begin
         if (!ctrl_a_ff.count_direction) begin                  // [R5]
            angle_ff <= (angle_ff == ANGLE_MAX) ?
                        9'h000 : angle_ff + 9'h001;             // [R19]
         end else begin
            angle_ff <= (angle_ff == 9'h000) ?
                        ANGLE_MAX : angle_ff - 9'h001;          // [R19]
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         capture_ff <= 9'h000;
      end else if (position_detect) begin
         capture_ff <= angle_ff;                                // [R17]
      end
   end

   // Calculation sequencer
   assign calc_start = ctrl_a_ff.waveform_calc_enable &
                       (sw_trig |                               // [R1]
                        (sync_en_ff & (timer_done | angle_wr))); // [R3]
   assign calc_done = (state_ff == CALC_RUN) & ~calc_start &
                      (calc_cnt_ff == CALC_LAST);               // [R20]

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff    <= CALC_IDLE;
         calc_cnt_ff <= 8'h00;
      end else if (!ctrl_a_ff.waveform_calc_enable) begin
         state_ff    <= CALC_IDLE;                              // [R11]
         calc_cnt_ff <= 8'h00;
      end else if (calc_start) begin
         state_ff    <= CALC_RUN;                               // [R1]
         calc_cnt_ff <= 8'h00;
      end else begin
         case (state_ff)
            CALC_RUN: begin
               if (calc_done) begin
                  state_ff    <= CALC_IDLE;
                  calc_cnt_ff <= 8'h00;
               end else begin
                  calc_cnt_ff <= calc_cnt_ff + 8'h01;
               end
            end
            default: begin
               state_ff    <= CALC_IDLE;
               calc_cnt_ff <= 8'h00;
            end
         endcase
      end
   end

   // Per phase: one table read in steps 1..3, one result in steps 2..4
   assign rd_phase = 2'(calc_cnt_ff - 8'h01);
   assign rd_addr = phase_angle(base_ff, rd_phase,
                                ctrl_a_ff.phase_order_select);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         base_ff     <= 9'h000;
         ph_angle_ff <= 9'h000;
      end else if (state_ff == CALC_RUN) begin
         if (calc_cnt_ff == 8'h00) begin
            base_ff <= angle_ff;
         end
         ph_angle_ff <= rd_addr;
      end
   end

   always_ff @(posedge mclk) begin
      ram_q_ff <= sine_ram[rd_addr];
   end

   always_comb begin
      logic [31:0] prod;
      logic [15:0] term;
      logic [16:0] sum;
      prod = 32'(ram_q_ff) * 32'(scale_ff);                     // [R16]
      term = 16'(prod >> PROD_SHIFT);
      if (term > pwm_period_setting) begin
         term = pwm_period_setting;                             // [R16]
      end
      sum = 17'h00000;
      if (!ctrl_a_ff.modulation_select) begin
         calc_value = term;                                     // [R8]
      end else begin
         if (ph_angle_ff <= ANGLE_HALF_MAX) begin               // [R9]
            sum = {1'b0, pwm_period_setting} + {2'b00, term[15:1]};
         end else begin
            sum = {1'b0, pwm_period_setting} - {2'b00, term[15:1]};
         end
         calc_value = sum[16] ? 16'hffff : sum[15:0];
      end
   end

   // Results and PWM compare registers, one set per phase
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_phase
         localparam logic [7:0] RES_STEP = 8'(gi + 2);
         localparam logic [5:0] CMP_OFS = OFS_CMP_U + 6'(gi * 4);

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               res_ff[gi] <= 16'h0000;
            end else if (state_ff == CALC_RUN && !calc_start &&
                         calc_cnt_ff == RES_STEP) begin
               res_ff[gi] <= calc_value;
            end
         end

         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               cmp_ff[gi] <= 16'h0000;
            end else if (calc_done &&
                         ctrl_a_ff.result_autotransfer_enable) begin
               cmp_ff[gi] <= res_ff[gi];                        // [R10]
            end else if (wr_en && avs_address == CMP_OFS &&
                         !ctrl_a_ff.result_autotransfer_enable) begin
               cmp_ff[gi] <= merge16(cmp_ff[gi], avs_writedata,
                                     avs_byteenable);           // [R22]
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= irq_sel_ff ? calc_done : timer_done;         // [R4]
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign u_phase_compare = cmp_ff[0];
   assign v_phase_compare = cmp_ff[1];
   assign w_phase_compare = cmp_ff[2];
   assign angle_irq       = irq_ff;

endmodule : angle_wave_unit
`default_nettype wire

// ==== hw/angle_wave_pkg.sv ====
// Constants, register map and field carriers for the angle timer and
// sine waveform unit.
// Assumes a 20 MHz system clock and a 32-bit Avalon-MM register bus.
package angle_wave_pkg;

   // Register byte addresses
   localparam logic [5:0] OFS_CALC_CTRL_B = 6'h00;
   localparam logic [5:0] OFS_TIMER_CTRL_A = 6'h04;
   localparam logic [5:0] OFS_SINE_PORT = 6'h08;
   localparam logic [5:0] OFS_PERIOD = 6'h0c;
   localparam logic [5:0] OFS_ANGLE = 6'h10;
   localparam logic [5:0] OFS_SCALE = 6'h14;
   localparam logic [5:0] OFS_CAPTURE = 6'h18;
   localparam logic [5:0] OFS_CMP_U = 6'h1c;
   localparam logic [5:0] OFS_CMP_V = 6'h20;
   localparam logic [5:0] OFS_CMP_W = 6'h24;

   // Calc control B bit positions
   localparam int BIT_SW_TRIG = 3;
   localparam int BIT_BUSY = 2;
   localparam int BIT_SYNC_EN = 1;
   localparam int BIT_IRQ_SEL = 0;

   // Period register fields
   localparam int CORR_MSB = 15;
   localparam int CORR_LSB = 12;
   localparam int PER_MSB = 11;

   // Reset values
   localparam logic [7:0] RST_CTRL_A = 8'h00;
   localparam logic [1:0] RST_CTRL_B = 2'h0;
   localparam logic [15:0] RST_PERIOD = 16'h0010;
   localparam logic [15:0] RST_SCALE = 16'h0000;

   // Angle range: one electrical cycle
   localparam logic [8:0] ANGLE_MAX = 9'h17f;
   localparam logic [8:0] ANGLE_HALF_MAX = 9'h0bf;
   localparam logic [9:0] ANGLE_SPAN = 10'h180;
   localparam logic [9:0] ANGLE_THIRD = 10'h080;
   localparam logic [9:0] ANGLE_TWO_THIRD = 10'h100;
   localparam int SINE_DEPTH = 384;

   // Smallest period value
   localparam logic [11:0] PERIOD_MIN = 12'h010;

   // Product scaling before the amplitude limit
   localparam int PROD_SHIFT = 8;

   // Calculation time: 140 clock cycles
   localparam int CLK_PERIOD_NS = 50;
   localparam int CALC_TIME_NS = 7000;
   localparam int CALC_CYCLES = CALC_TIME_NS / CLK_PERIOD_NS;
   localparam logic [7:0] CALC_LAST = 8'(CALC_CYCLES - 1);

   typedef struct packed {
      logic       count_direction;
      logic       phase_order_select;
      logic [1:0] timer_clock_select;
      logic       modulation_select;
      logic       result_autotransfer_enable;
      logic       waveform_calc_enable;
      logic       angle_timer_enable;
   } timer_ctrl_t;

   typedef struct packed {
      logic [3:0]  period_correction_count;
      logic [11:0] period_value;
   } period_t;

   typedef enum logic [1:0] {
      CALC_IDLE = 2'b00,
      CALC_RUN  = 2'b01
   } calc_state_t;

endpackage : angle_wave_pkg

// ==== sim/angle_wave_unit_props.sv ====
// Port checker for the angle timer and waveform unit.
// Assumes the port list of angle_wave_unit; bound at the foot of the file.
`timescale 1ns/1ns
`default_nettype none
module angle_wave_unit_props
   import angle_wave_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [15:0] u_phase_compare,
   input wire logic        angle_irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   chk_wait_answer: assert property (($rose(avs_read) || $rose(avs_write))
      |=> !avs_waitrequest) else $error("request not answered in one cycle");
   chk_wait_idle: assert property (!(avs_read || avs_write)
      |=> avs_waitrequest) else $error("waitrequest low with no request");
   chk_wait_stands: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_wait_cause: assert property (!avs_waitrequest
      |-> $past(avs_read || avs_write)) else $error("answer without request");
   chk_reset_quiet: assert property ($rose(rst_n) |-> avs_waitrequest
      && !angle_irq && u_phase_compare == 16'h0000)
      else $error("outputs not quiet after reset");
   chk_unmapped_zero: assert property (avs_read && !avs_waitrequest
      && avs_address == 6'h28 |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   chk_trigger_reads_zero: assert property (
      avs_read && !avs_waitrequest && avs_address == OFS_CALC_CTRL_B
      |-> !avs_readdata[BIT_SW_TRIG]) else $error("trigger bit read as one");
   chk_irq_pulse: assert property (angle_irq |=> !angle_irq)
      else $error("interrupt longer than one cycle");
   chk_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
endmodule : angle_wave_unit_props

bind angle_wave_unit angle_wave_unit_props chk (
   .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .u_phase_compare(u_phase_compare), .angle_irq(angle_irq));
`default_nettype wire

// ==== sim/pwm_partner.sv ====
// Model of the PWM circuit: supplies its period, holds the U phase duty value.
// Assumes compare outputs are steady between updates.
`timescale 1ns/1ns
`default_nettype none
module pwm_partner #(
   parameter logic [15:0] PERIOD = 16'h1000
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [15:0] u_phase_compare,
   input  wire logic [15:0] v_phase_compare,
   input  wire logic [15:0] w_phase_compare,
   output logic [15:0]      pwm_period_setting,
   output logic [15:0]      duty_u_ff
);
   assign pwm_period_setting = PERIOD;

   // Duty follows whatever the unit places in the U phase compare register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) duty_u_ff <= 16'h0000;
      else duty_u_ff <= u_phase_compare;
   end
endmodule : pwm_partner
`default_nettype wire

// ==== sim/test_angle_wave_unit.sv ====
// Self-checking bench for angle_wave_unit with the PWM partner model.
// Assumes the one-cycle Avalon answer and 140-cycle calculation.
`timescale 1ns/1ns
`default_nettype none
module test_angle_wave_unit;
   import angle_wave_pkg::*;
   localparam logic [15:0] PWM = 16'h1000;
   logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest;
   logic        position_detect, angle_irq;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [15:0] pwm_period_setting, u_cmp, v_cmp, w_cmp, duty_u;
   logic [15:0] lfsr, scale, res_u;
   logic [31:0] exp_q[$];
   int          errors, num_checks, irqs;

   angle_wave_unit dut (.mclk(mclk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .position_detect(position_detect),
      .pwm_period_setting(pwm_period_setting), .u_phase_compare(u_cmp),
      .v_phase_compare(v_cmp), .w_phase_compare(w_cmp),
      .angle_irq(angle_irq));
   pwm_partner #(.PERIOD(PWM)) far (.mclk(mclk), .rst_n(rst_n),
      .u_phase_compare(u_cmp), .v_phase_compare(v_cmp),
      .w_phase_compare(w_cmp), .pwm_period_setting(pwm_period_setting),
      .duty_u_ff(duty_u));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : tally_and_finish

   // One Avalon cycle; held until waitrequest is seen low at a rising edge
   task automatic bus(input logic [5:0] a, input logic w,
                      input logic [15:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {16'h0000, d};
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         errors++;
         tally_and_finish();
      end
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      bus(a, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      exp_q.push_back({16'h0000, e});
      bus(a, 1'b0, 16'h0000);
   endtask : rd

   // Monitor: each read answer takes the oldest expectation
   always @(posedge mclk) begin
      if (angle_irq === 1'b1) irqs++;
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) check(avs_readdata, 32'hdead_beef);
         else check(avs_readdata, exp_q.pop_front());
      end
   end

   function automatic logic [15:0] ph_exp(input int ang,
                                          input logic three);
      logic [31:0] t;
      t = (32'(16'(ang * 3)) * 32'(scale)) >> 8;
      if (t > 32'(PWM)) t = 32'(PWM);
      if (three) t = (ang <= 191) ? 32'(PWM) + t / 2 : 32'(PWM) - t / 2;
      return t[15:0];
   endfunction : ph_exp

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   // Software-started calculation and readback of all three phases
   task automatic calc(input int a, input logic [7:0] ca,
                       input logic isel);
      int vo, wo, i0;
      vo = ca[6] ? 256 : 128;
      wo = ca[6] ? 128 : 256;
      wr(OFS_TIMER_CTRL_A, {8'h00, ca});
      wr(OFS_ANGLE, 16'(a));
      i0 = irqs;
      wr(OFS_CALC_CTRL_B, {12'h000, 3'b100, isel});
      rd(OFS_CALC_CTRL_B, {12'h000, 3'b010, isel});
      repeat (150) @(posedge mclk);
      rd(OFS_CALC_CTRL_B, {15'h0000, isel});
      res_u = ph_exp(a, ca[3]);
      rd(OFS_CMP_U, res_u);
      rd(OFS_CMP_V, ph_exp((a + vo) % 384, ca[3]));
      rd(OFS_CMP_W, ph_exp((a + wo) % 384, ca[3]));
      check(32'(irqs - i0), 32'(isel));
   endtask : calc

   initial begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      position_detect = 1'b0;
      lfsr = 16'd37542;
      scale = 16'h0100;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      rd(OFS_TIMER_CTRL_A, 16'(RST_CTRL_A));
      rd(OFS_PERIOD, RST_PERIOD);
      rd(OFS_SCALE, RST_SCALE);
      rd(6'h28, 16'h0000);
      lfsr = lfsr_next(lfsr);
      wr(OFS_TIMER_CTRL_A, lfsr & 16'h00f8);
      rd(OFS_TIMER_CTRL_A, lfsr & 16'h00f8);
      wr(OFS_TIMER_CTRL_A, 16'h0000);
      wr(OFS_ANGLE, 16'h017f);
      wr(OFS_ANGLE, 16'h0180);
      rd(OFS_ANGLE, 16'h017f);
      // Table fill with the arithmetic unit off
      for (int a = 0; a < 384; a++) begin
         wr(OFS_ANGLE, 16'(a));
         wr(OFS_SINE_PORT, 16'(a * 3));
      end
      wr(OFS_SCALE, scale);
      calc(10, 8'h02, 1'b0);
      calc(300, 8'h42, 1'b0);
      calc(191, 8'h0a, 1'b0);
      calc(192, 8'h4a, 1'b0);
      scale = 16'hffff;
      wr(OFS_SCALE, scale);
      calc(64, 8'h02, 1'b0);
      scale = 16'h0100;
      wr(OFS_SCALE, scale);
      calc(5, 8'h06, 1'b1);
      check(32'(u_cmp), 32'(res_u));
      check(32'(duty_u), 32'(res_u));
      check(32'(v_cmp), 32'(ph_exp(133, 1'b0)));
      check(32'(w_cmp), 32'(ph_exp(261, 1'b0)));
      wr(OFS_TIMER_CTRL_A, 16'h0004);
      wr(OFS_CMP_U, 16'h1234);
      rd(OFS_CMP_U, res_u);
      // Angle write starts a calculation when sync is on
      wr(OFS_TIMER_CTRL_A, 16'h0002);
      wr(OFS_CALC_CTRL_B, 16'h0002);
      wr(OFS_ANGLE, 16'h0033);
      rd(OFS_CALC_CTRL_B, 16'h0006);
      repeat (150) @(posedge mclk);
      wr(OFS_CALC_CTRL_B, 16'h0000);
      // Period below the minimum, counting down from zero
      wr(OFS_TIMER_CTRL_A, 16'h0000);
      wr(OFS_PERIOD, 16'h0005);
      wr(OFS_TIMER_CTRL_A, 16'h0081);
      repeat (200) @(posedge mclk);
      rd(OFS_ANGLE, 16'h017f);
      wr(OFS_TIMER_CTRL_A, 16'h0000);
      rd(OFS_ANGLE, 16'h0000);
      // Correction 15 of 16: seven steps by now, eight without it
      wr(OFS_PERIOD, 16'hf010);
      wr(OFS_TIMER_CTRL_A, 16'h0001);
      repeat (1040) @(posedge mclk);
      rd(OFS_ANGLE, 16'h0007);
      wr(OFS_TIMER_CTRL_A, 16'h0000);
      // Slowest clock: one step of 16 ticks of 64 clocks
      wr(OFS_PERIOD, 16'h0010);
      wr(OFS_TIMER_CTRL_A, 16'h0031);
      repeat (1040) @(posedge mclk);
      rd(OFS_ANGLE, 16'h0001);
      wr(OFS_TIMER_CTRL_A, 16'h0000);
      lfsr = lfsr_next(lfsr);
      wr(OFS_ANGLE, lfsr % 16'd384);
      @(posedge mclk);
      position_detect <= 1'b1;
      @(posedge mclk);
      position_detect <= 1'b0;
      rd(OFS_CAPTURE, lfsr % 16'd384);
      repeat (4) @(posedge mclk);
      if (exp_q.size() != 0) errors++;
      tally_and_finish();
   end
endmodule : test_angle_wave_unit
`default_nettype wire
